// ### pbs_pkg.sv
// Purpose: shared constants and types for the pipelined burst sram core
// Assumes: single clock, inputs except oe and sleep synchronous to ref_clk_in
// Notes: array geometry and timing counts live here
package pbs_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam int SLEEP_ENTER_CYC = 2;
  localparam int SLEEP_EXIT_CYC = 2;
  localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
  localparam logic [1:0] SLEEP_CNT_ONE = 2'h1;
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_ZERO = 2'h0;
  typedef enum logic [2:0] {
    PBS_IDLE = 3'b001,
    PBS_READ = 3'b010,
    PBS_WRITE = 3'b100
  } pbs_cycle_t;
endpackage

// ### pbs_burst_if.sv
// Purpose: carries burst counter controls between core and counter
// Assumes: one clock domain
// Notes: load takes priority over advance
`timescale 1ns/1ps
interface pbs_burst_if;
  logic load;
  logic advance;
  logic order_interleaved;
  logic [1:0] start;
  logic [1:0] low_bits;
  modport core (output load, output advance, output order_interleaved, output start,
    input low_bits);
  modport counter (input load, input advance, input order_interleaved, input start,
    output low_bits);
endinterface

// ### pbs_burst_counter.sv
// Purpose: 2-bit burst address sequencer, linear or interleaved
// Assumes: load and advance sampled on rising edge
// Notes: wraps to the start after four words
`timescale 1ns/1ps
module pbs_burst_counter (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  pbs_burst_if.counter bus
);
  logic [1:0] start;
  logic [1:0] step;
  logic [1:0] next_start;
  logic [1:0] next_step;

  always_comb begin
    next_start = start;
    next_step = step;
    if (bus.load) begin
      next_start = bus.start;
      next_step = pbs_pkg::STEP_ZERO;
    end else if (bus.advance) begin
      next_step = step + pbs_pkg::STEP_ONE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start <= pbs_pkg::STEP_ZERO;
      step <= pbs_pkg::STEP_ZERO;
    end else begin
      start <= next_start;
      step <= next_step;
    end
  end

  // interleaved xors the step in, linear adds it
  assign bus.low_bits = bus.order_interleaved ? (start ^ step) : (start + step);

  property p_wrap;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (!bus.load && bus.advance && step == 2'h3) |=> step == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst step did not wrap");
endmodule // pbs_burst_counter

// ### pbs_sram_core.sv
// Purpose: device-side logic of a 32K x 32 two-stage pipelined burst sram
// Assumes: all inputs except oe and sleep are synchronous to ref_clk_in
// Notes: data pins are split into in, out and output enable
`timescale 1ns/1ps
module pbs_sram_core #(
  parameter int ADDR_W = pbs_pkg::ADDR_W,
  parameter int DATA_W = pbs_pkg::DATA_W
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic select_primary_n_in,
  input wire logic select_expansion_in,
  input wire logic select_third_n_in,
  input wire logic processor_addr_strobe_n_in,
  input wire logic controller_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic global_write_n_in,
  input wire logic byte_write_gate_n_in,
  input wire logic [3:0] lane_write_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_select_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] dq_oe_out,
  output logic powered_down_out
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int LW = pbs_pkg::LANE_W;

  pbs_burst_if burst ();
  pbs_burst_counter u_counter (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .bus(burst)
  );

  pbs_pkg::pbs_cycle_t cycle;
  pbs_pkg::pbs_cycle_t next_cycle;
  pbs_pkg::pbs_cycle_t stage1_cycle;
  pbs_pkg::pbs_cycle_t next_stage1_cycle;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] next_base_addr;
  logic [DATA_W-1:0] stage1_data;
  logic [DATA_W-1:0] next_stage1_data;
  logic [DATA_W-1:0] stage2_data;
  logic [DATA_W-1:0] next_stage2_data;
  logic stage2_valid;
  logic next_stage2_valid;
  logic [1:0] sleep_cnt;
  logic [1:0] next_sleep_cnt;
  logic powered_down;
  logic next_powered_down;

  logic selected;
  logic start_proc;
  logic start_ctrl;
  logic deselect;
  logic [3:0] write_lanes;
  logic write_any;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] array_word;
  logic [DATA_W-1:0] merged_word;
  logic drive_en;

  assign selected = !select_primary_n_in && select_expansion_in && !select_third_n_in;
  assign start_proc = selected && !processor_addr_strobe_n_in;
  assign start_ctrl = selected && processor_addr_strobe_n_in
    && !controller_addr_strobe_n_in;
  // processor strobe is blocked while primary select is high
  assign deselect = (!processor_addr_strobe_n_in && !select_primary_n_in && !selected)
    || (!controller_addr_strobe_n_in && !selected);

  // lane write decode
  always_comb begin
    write_lanes = pbs_pkg::LANES_NONE;
    if (!global_write_n_in) begin
      write_lanes = pbs_pkg::LANES_ALL;
    end else if (!byte_write_gate_n_in) begin
      write_lanes = ~lane_write_n_in;
    end
  end
  assign write_any = write_lanes != pbs_pkg::LANES_NONE;

  assign cur_addr = {base_addr[ADDR_W-1:pbs_pkg::BURST_W], burst.low_bits};

  // cycle sequencing and burst counter control
  always_comb begin
    next_cycle = cycle;
    next_base_addr = base_addr;
    burst.load = 1'b0;
    burst.advance = 1'b0;
    burst.start = addr_in[1:0];
    burst.order_interleaved = burst_order_select_in;
    if (powered_down) begin
      next_cycle = cycle;
    end else if (start_proc) begin
      next_cycle = pbs_pkg::PBS_READ;
      next_base_addr = addr_in;
      burst.load = 1'b1;
    end else if (start_ctrl) begin
      next_cycle = write_any ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
      next_base_addr = addr_in;
      burst.load = 1'b1;
    end else if (deselect) begin
      next_cycle = pbs_pkg::PBS_IDLE;
    end else if (cycle != pbs_pkg::PBS_IDLE) begin
      next_cycle = write_any ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
      burst.advance = !burst_advance_n_in;
    end
  end

  // write data lands on the edge after the cycle is set up, so a write
  // continues using lanes sampled on the edge that stores the data
  generate
    for (genvar l = 0; l < pbs_pkg::LANES; l++) begin : g_lane
      // one array per lane so each lane has a single writing process
      logic [LW-1:0] lane_mem [DEPTH];
      always_ff @(posedge ref_clk_in) begin
        if (!powered_down && cycle == pbs_pkg::PBS_WRITE && write_lanes[l]) begin
          lane_mem[cur_addr] <= dq_in[l*LW +: LW];
        end
      end
      assign array_word[l*LW +: LW] = lane_mem[cur_addr];
      // pass-through of the lanes written on this edge
      assign merged_word[l*LW +: LW] = write_lanes[l] ? dq_in[l*LW +: LW]
        : array_word[l*LW +: LW];
    end
  endgenerate

  // two-stage read pipeline
  always_comb begin
    next_stage1_cycle = powered_down ? stage1_cycle : cycle;
    next_stage1_data = stage1_data;
    next_stage2_data = stage2_data;
    next_stage2_valid = stage2_valid;
    if (!powered_down) begin
      if (cycle == pbs_pkg::PBS_WRITE) begin
        next_stage1_data = merged_word;
      end else begin
        next_stage1_data = array_word;
      end
      next_stage2_data = stage1_data;
      // a deselect drops the drivers one edge later, even with a word in flight
      next_stage2_valid = stage1_cycle != pbs_pkg::PBS_IDLE
        && cycle != pbs_pkg::PBS_IDLE;
    end
  end

  localparam logic [1:0] SLEEP_LAST = 2'(pbs_pkg::SLEEP_ENTER_CYC - 1);

  // sleep entry and exit counts
  always_comb begin
    next_sleep_cnt = sleep_cnt;
    next_powered_down = powered_down;
    if (sleep_request_in != powered_down) begin
      if (sleep_cnt == SLEEP_LAST) begin
        next_powered_down = sleep_request_in;
        next_sleep_cnt = pbs_pkg::SLEEP_CNT_ZERO;
      end else begin
        next_sleep_cnt = sleep_cnt + pbs_pkg::SLEEP_CNT_ONE;
      end
    end else begin
      next_sleep_cnt = pbs_pkg::SLEEP_CNT_ZERO;
    end
  end
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cycle <= pbs_pkg::PBS_IDLE;
      stage1_cycle <= pbs_pkg::PBS_IDLE;
      base_addr <= '0;
      stage1_data <= '0;
      stage2_data <= '0;
      stage2_valid <= 1'b0;
      sleep_cnt <= pbs_pkg::SLEEP_CNT_ZERO;
      powered_down <= 1'b0;
    end else begin
      cycle <= next_cycle;
      stage1_cycle <= next_stage1_cycle;
      base_addr <= next_base_addr;
      stage1_data <= next_stage1_data;
      stage2_data <= next_stage2_data;
      stage2_valid <= next_stage2_valid;
      sleep_cnt <= next_sleep_cnt;
      powered_down <= next_powered_down;
    end
  end

  // drivers off during a write cycle whatever oe says
  assign drive_en = stage2_valid && cycle != pbs_pkg::PBS_WRITE
    && !output_enable_n_in && !sleep_request_in;
  assign dq_out = stage2_data;
  assign dq_oe_out = {DATA_W{drive_en}};
  assign powered_down_out = powered_down;

  property p_sleep_off;
    @(posedge ref_clk_in) disable iff (!resetn_in) sleep_request_in |-> dq_oe_out == '0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("pins driven during sleep");
  property p_release;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (cycle == pbs_pkg::PBS_IDLE && !powered_down) |=> !stage2_valid;
  endproperty
  a_release: assert property (p_release) else $error("drivers held after deselect");
  property p_hold;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (cycle != pbs_pkg::PBS_IDLE && !powered_down && !start_proc && !start_ctrl
        && !deselect && burst_advance_n_in) |=> $stable(cur_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("suspend moved the address");
  property p_read_decode;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (global_write_n_in && byte_write_gate_n_in) |-> !write_any;
  endproperty
  a_read_decode: assert property (p_read_decode) else $error("read decoded as write");
  property p_oe_off;
    @(posedge ref_clk_in) disable iff (!resetn_in) output_enable_n_in |-> dq_oe_out == '0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pins driven with oe high");
  property p_proc_read;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (start_proc && !powered_down) |=> cycle == pbs_pkg::PBS_READ;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("proc start not read");
  property p_ctrl_write;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (start_ctrl && write_any && !powered_down) |=> cycle == pbs_pkg::PBS_WRITE;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write missed");
  property p_desel;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (deselect && !start_proc && !start_ctrl && !powered_down) |=> cycle == pbs_pkg::PBS_IDLE;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect ignored");
  property p_gw_all;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      !global_write_n_in |-> write_lanes == pbs_pkg::LANES_ALL;
  endproperty
  a_gw_all: assert property (p_gw_all) else $error("global write not all lanes");
  property p_sleep_enter;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      ($rose(sleep_request_in) && !powered_down) ##1 sleep_request_in |=> powered_down;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry late");
  property p_wake;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (!powered_down && !sleep_request_in) |=> !powered_down;
  endproperty
  a_wake: assert property (p_wake) else $error("spurious power down");
  property p_pipe;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (!powered_down ##1 !powered_down) |-> stage2_data == $past(stage1_data);
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline stage skipped");
  c_read: cover property (@(posedge ref_clk_in) start_proc ##3 drive_en);
  c_write: cover property (@(posedge ref_clk_in) start_ctrl && write_any);
  c_sleep: cover property (@(posedge ref_clk_in) powered_down);
endmodule // pbs_sram_core

// ### pbs_far_model.sv
// Purpose: far-side bus master model for the burst sram core
// Assumes: every synchronous input changes at the falling edge
// Notes: undriven dq shows the inverse of its last value
`timescale 1ns/1ps
module pbs_far_model (
  input wire logic clk_in,
  input wire logic [31:0] dq_dev_in,
  input wire logic [31:0] dq_oe_in,
  output logic [7:0] ctl_out,
  output logic [3:0] lanes_out,
  output logic [14:0] addr_out,
  output logic oe_n_out,
  output logic sleep_out,
  output logic [31:0] dq_out
);
  logic oe_hi;
  logic wd;
  logic [31:0] wdat;
  logic [31:0] last;
  initial begin
    ctl_out = 8'hd7;
    lanes_out = 4'hf;
    addr_out = 15'h0000;
    sleep_out = 1'b0;
    oe_hi = 1'b0;
    wd = 1'b0;
    wdat = 32'h0000_0000;
    last = 32'h0000_0000;
  end
  // drivers off whenever write data goes out
  assign oe_n_out = oe_hi | wd;
  // a released bus never keeps the old value
  assign dq_out = dq_oe_in[0] ? dq_dev_in : (wd ? wdat : ~last);
  always @(posedge clk_in) last <= dq_out;
  task automatic drive(input logic [7:0] c, input logic [3:0] l, input logic [14:0] a,
    input logic w, input logic [31:0] d);
    @(negedge clk_in);
    ctl_out = c;
    lanes_out = l;
    addr_out = a;
    wd = w;
    wdat = d;
  endtask
  task automatic nap(input logic v);
    @(negedge clk_in);
    sleep_out = v;
  endtask
endmodule // pbs_far_model

// ### test_pbs_sram_core.sv
// Purpose: self-checking bench for the pipelined burst sram core
// Assumes: far model drives the bus at falling edges
// Notes: ctl bits are selects, strobes, advance, global write, gate
`timescale 1ns/1ps
module test_pbs_sram_core;
  localparam logic [7:0] PARK = 8'hd7;
  localparam logic [7:0] IDLE = 8'hdf;
  localparam logic [7:0] CONT = 8'h5b;
  localparam logic [7:0] SUSP = 8'h5f;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ord = 1'b0;
  logic [7:0] ctl;
  logic [3:0] ln;
  logic [14:0] addr;
  logic oe_n;
  logic slp;
  logic [31:0] fdq;
  logic [31:0] dq;
  logic [31:0] dq_oe;
  logic pd;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] mem [int];
  initial forever #12.5 clk = ~clk;
  pbs_sram_core dut (.ref_clk_in(clk), .resetn_in(rstn), .addr_in(addr),
    .select_primary_n_in(ctl[7]), .select_expansion_in(ctl[6]), .select_third_n_in(ctl[5]),
    .processor_addr_strobe_n_in(ctl[4]), .controller_addr_strobe_n_in(ctl[3]),
    .burst_advance_n_in(ctl[2]), .global_write_n_in(ctl[1]), .byte_write_gate_n_in(ctl[0]),
    .lane_write_n_in(ln), .output_enable_n_in(oe_n), .sleep_request_in(slp),
    .burst_order_select_in(ord), .dq_in(fdq), .dq_out(dq), .dq_oe_out(dq_oe),
    .powered_down_out(pd));
  pbs_far_model far (.clk_in(clk), .dq_dev_in(dq), .dq_oe_in(dq_oe), .ctl_out(ctl),
    .lanes_out(ln), .addr_out(addr), .oe_n_out(oe_n), .sleep_out(slp), .dq_out(fdq));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // last word is held one extra cycle under PARK, which writes no lanes, so only the first edge stores it
  task automatic wr(input logic [7:0] st, input logic [7:0] cn, input logic [3:0] l,
    input logic [14:0] a, input int n);
    logic [31:0] d;
    int k;
    ord = 1'b0;
    far.drive(st, l, a, 1'b0, 32'h0000_0000);
    for (int j = 0; j < n; j++) begin
      d = {8'h5a, a[7:0], 8'hc3, 8'(j)};
      k = {a[14:2], a[1:0] + 2'(j)};
      far.drive((j == n - 1) ? (cn | 8'h04) : cn, l, a, 1'b1, d);
      for (int b = 0; b < 4; b++) begin
        if (!cn[1] || (!cn[0] && !l[b])) mem[k][b*8+:8] = d[b*8+:8];
      end
    end
    far.drive(PARK, l, a, 1'b1, d);
    far.drive(PARK, 4'hf, a, 1'b0, 32'h0000_0000);
    $display("write test done");
  endtask
  task automatic rd(input logic [7:0] st, input logic [14:0] a, input logic o,
    input logic sus);
    logic [14:0] wa;
    int s;
    ord = o;
    far.drive(st, 4'h0, a, 1'b0, 32'h0000_0000);
    for (int j = 1; j <= 6; j++) begin
      far.drive((sus && j == 1) ? SUSP : CONT, 4'h0, a, 1'b0, 32'h0000_0000);
      if (j >= 3) begin
        s = j - 3 - ((sus && j >= 4) ? 1 : 0);
        wa = {a[14:2], o ? (a[1:0] ^ 2'(s)) : (a[1:0] + 2'(s))};
        chk("dq_oe read", {32{~far.oe_hi}}, dq_oe);
        if (!far.oe_hi) chk("dq read", mem[int'(wa)], dq);
      end
    end
    repeat (3) far.drive(PARK, 4'hf, a, 1'b0, 32'h0000_0000);
    chk("dq_oe released", 32'h0000_0000, dq_oe);
    $display("read test done");
  endtask
  task automatic desel;
    far.drive(8'h0f, 4'h0, 15'h0010, 1'b0, 32'h0000_0000);
    repeat (5) begin
      far.drive(CONT, 4'h0, 15'h0010, 1'b0, 32'h0000_0000);
      chk("dq_oe deselected", 32'h0000_0000, dq_oe);
    end
    $display("deselect test done");
  endtask
  task automatic nap;
    far.drive(8'h4f, 4'h0, 15'h0010, 1'b0, 32'h0000_0000);
    repeat (3) far.drive(CONT, 4'h0, 15'h0010, 1'b0, 32'h0000_0000);
    chk("dq_oe before sleep", 32'hffff_ffff, dq_oe);
    far.nap(1'b1);
    // let the unclocked driver kill settle before looking
    #1;
    chk("dq_oe asleep", 32'h0000_0000, dq_oe);
    far.drive(PARK, 4'hf, 15'h0010, 1'b0, 32'h0000_0000);
    chk("early power-down", 32'(1'b0), 32'(pd));
    repeat (2) far.drive(PARK, 4'hf, 15'h0010, 1'b0, 32'h0000_0000);
    chk("power-down", 32'(1'b1), 32'(pd));
    far.nap(1'b0);
    // strobes stay high while waking
    repeat (3) far.drive(IDLE, 4'hf, 15'h0010, 1'b0, 32'h0000_0000);
    chk("wake", 32'(1'b0), 32'(pd));
    far.drive(PARK, 4'hf, 15'h0010, 1'b0, 32'h0000_0000);
    $display("sleep test done");
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    chk("dq_oe after reset", 32'h0000_0000, dq_oe);
    chk("pd after reset", 32'(1'b0), 32'(pd));
    wr(8'h55, 8'h59, 4'hf, 15'h0012, 4);
    rd(8'h4f, 15'h0012, 1'b0, 1'b0);
    rd(8'h57, 15'h0011, 1'b1, 1'b1);
    wr(8'h56, 8'h5e, 4'ha, 15'h0011, 1);
    wr(8'h57, 8'h5f, 4'h0, 15'h0013, 1);
    rd(8'h4f, 15'h0010, 1'b0, 1'b0);
    far.oe_hi = 1'b1;
    rd(8'h4f, 15'h0010, 1'b0, 1'b0);
    far.oe_hi = 1'b0;
    desel();
    nap();
    rd(8'h4f, 15'h0013, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule // test_pbs_sram_core
